/* adcc_pkg.sv */
/*
  Constants for the converter control block: register indices,
  field positions, sequencing counts and state codes.
  Assumes a 32-bit AXI4-Lite bus with 12-bit byte addresses.
*/
package adcc_pkg;

  // ==========================================================
  // Register map: printed index, byte address is four times it
  // ==========================================================
  localparam int          ADDR_W    = 12;
  localparam logic [9:0]  CTRL_IDX  = 10'h0C5;
  localparam logic [9:0]  RES_IDX   = 10'h0C6;
  localparam logic [11:0] CTRL_ADDR = {CTRL_IDX, 2'h0};
  localparam logic [11:0] RES_ADDR  = {RES_IDX, 2'h0};
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  // ==========================================================
  // Control register fields
  // ==========================================================
  localparam int B_RLO1 = 7;
  localparam int B_RLO0 = 6;
  localparam int B_EXT  = 5;
  localparam int B_DONE = 4;
  localparam int B_BUSY = 3;
  localparam int CH_W   = 3;

  // ==========================================================
  // Sequencing in machine cycles
  // ==========================================================
  localparam int          RES_W     = 10;
  localparam int          INIT_MC   = 2;
  localparam int          SAMPLE_MC = 8;
  localparam int          BIT_MC    = 4;
  localparam int          CONV_MC   = INIT_MC + SAMPLE_MC + BIT_MC * RES_W;
  localparam int          CNT_W     = 6;
  localparam logic [5:0]  SMP_LAST  = 6'(SAMPLE_MC - 1);
  localparam logic [5:0]  BITS_LAST = 6'(BIT_MC * RES_W - 1);
  localparam logic [5:0]  AGE_END   = 6'(CONV_MC - 1);
  localparam logic [1:0]  DECIDE_PH = 2'h2;
  localparam logic [9:0]  SAR_MSB   = 10'h200;

  // Gray codes along idle, init, init, sample, resolve
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INIT1  = 3'h1,
    ST_INIT2  = 3'h3,
    ST_SAMPLE = 3'h2,
    ST_CONV   = 3'h6
  } adcc_state_type;

endpackage : adcc_pkg

/* adcc_sar.sv */
/*
  Successive approximation register for the converter.
  Assumes an external DAC and comparator: cmp_above is high
  when the sampled input is at or above dac_code.
*/
`timescale 1ns/1ps
module adcc_sar (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       load,
  input  wire logic       decide,
  input  wire logic       cmp_above,
  output logic [9:0]      dac_code
);

  logic [9:0] code_reg;
  logic [9:0] code_next;
  logic [9:0] mask_reg;
  logic [9:0] mask_next;

  // ==========================================================
  // Trial code
  // ==========================================================
  // Load starts at mid scale; each decision keeps or drops one bit
  always_comb begin
    code_next = code_reg;
    mask_next = mask_reg;
    if (load) begin
      code_next = adcc_pkg::SAR_MSB;
      mask_next = adcc_pkg::SAR_MSB;
    end else if (decide) begin
      code_next = (cmp_above ? code_reg : (code_reg & ~mask_reg))
                  | (mask_reg >> 1);
      mask_next = mask_reg >> 1;
    end
  end

  // Held while the clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg <= 10'h000;
      mask_reg <= 10'h000;
    end else if (ce) begin
      code_reg <= code_next;
      mask_reg <= mask_next;
    end
  end

  assign dac_code = code_reg;

endmodule : adcc_sar

/* adcc_top.sv */
/*
  Converter control: start logic, conversion sequencer,
  control/status and result registers on AXI4-Lite.
  Assumes one clock edge per machine cycle and an external
  analog mux, DAC and comparator.
*/
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module adcc_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        idle_mode,
  input  wire logic        power_down,
  input  wire logic        external_start_pin,
  input  wire logic        cmp_above,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [2:0]       analog_channel_sel,
  output logic             sample_en,
  output logic [9:0]       dac_code,
  output logic             conversion_done_flag
);

  // ==========================================================
  // Helpers
  // ==========================================================
  // Address decode shared by the write and read paths
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == adcc_pkg::CTRL_ADDR) || (a == adcc_pkg::RES_ADDR);
  endfunction : is_mapped

  // ==========================================================
  // Declarations
  // ==========================================================
  logic        aw_held_reg;
  logic        aw_held_next;
  logic [11:0] aw_addr_reg;
  logic [11:0] aw_addr_next;
  logic        w_held_reg;
  logic        w_held_next;
  logic [7:0]  w_data_reg;
  logic [7:0]  w_data_next;
  logic        w_strb_reg;
  logic        w_strb_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic        wr_fire;
  logic        wr_ctrl;
  logic [7:0]  ctrl_view;

  adcc_pkg::adcc_state_type state_reg;
  adcc_pkg::adcc_state_type state_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic        start_busy_bit_reg;
  logic        start_busy_bit_next;
  logic        conversion_done_flag_reg;
  logic        conversion_done_flag_next;
  logic        external_start_enable_reg;
  logic        external_start_enable_next;
  logic [2:0]  channel_select_reg;
  logic [2:0]  channel_select_next;
  logic [7:0]  result_high_byte_reg;
  logic [7:0]  result_high_byte_next;
  logic [1:0]  result_low_reg;
  logic [1:0]  result_low_next;
  logic        pin_prev_reg;
  logic        abort;
  logic        done_after_wr;
  logic        sw_start;
  logic        ext_rise;
  logic        start_ok;
  logic        conv_end;
  logic        sar_load;
  logic        sar_decide;

  // ==========================================================
  // AXI4-Lite write channel
  // ==========================================================
  // Address and data are taken in either order and held
  assign awready = ce & ~aw_held_reg & ~bvalid_reg;
  assign wready  = ce & ~w_held_reg & ~bvalid_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_ctrl = ce & wr_fire & w_strb_reg
                   & (aw_addr_reg == adcc_pkg::CTRL_ADDR);

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next  = w_held_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (awvalid && awready) begin
      aw_held_next = 1'h1;
      aw_addr_next = awaddr;
    end
    if (wvalid && wready) begin
      w_held_next = 1'h1;
      w_data_next = wdata[7:0];
      w_strb_next = wstrb[0];
    end
    if (wr_fire) begin
      aw_held_next = 1'h0;
      w_held_next  = 1'h0;
      bvalid_next  = 1'h1;
      bresp_next   = is_mapped(aw_addr_reg) ? adcc_pkg::RESP_OKAY
                                            : adcc_pkg::RESP_ERR;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'h0;
      aw_addr_reg <= 12'h000;
      w_held_reg  <= 1'h0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'h0;
      bvalid_reg  <= 1'h0;
      bresp_reg   <= 2'h0;
    end else if (ce) begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg  <= w_held_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // ==========================================================
  // AXI4-Lite read channel
  // ==========================================================
  // low bits read-only
  assign ctrl_view = {result_low_reg, external_start_enable_reg,
                      conversion_done_flag_reg, start_busy_bit_reg,
                      channel_select_reg};
  assign arready = ce & ~rvalid_reg;

  // Data is registered at the address handshake
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (arvalid && arready) begin
      rvalid_next = 1'h1;
      rresp_next  = is_mapped(araddr) ? adcc_pkg::RESP_OKAY
                                      : adcc_pkg::RESP_ERR;
      if (araddr == adcc_pkg::CTRL_ADDR) begin
        rdata_next = {24'h000000, ctrl_view};
      end else if (araddr == adcc_pkg::RES_ADDR) begin
        rdata_next = {24'h000000, result_high_byte_reg};
      end else begin
        rdata_next = 32'h00000000;
      end
    end else if (rvalid_reg && rready) begin
      rvalid_next = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'h0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= 2'h0;
    end else if (ce) begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign rvalid = rvalid_reg;
  assign rdata  = rdata_reg;
  assign rresp  = rresp_reg;

  // ==========================================================
  // Start qualification
  // ==========================================================
  // idle or power-down abort
  assign abort = idle_mode | power_down;
  assign done_after_wr = wr_ctrl ? (conversion_done_flag_reg
                                    & w_data_reg[adcc_pkg::B_DONE])
                                 : conversion_done_flag_reg;
  assign sw_start = wr_ctrl & w_data_reg[adcc_pkg::B_BUSY];
  assign ext_rise = external_start_enable_reg & external_start_pin
                    & ~pin_prev_reg;
  assign start_ok = (state_reg == adcc_pkg::ST_IDLE) & ~start_busy_bit_reg
                    & ~done_after_wr & ~abort & (sw_start | ext_rise);
  assign conv_end = ~abort & (state_reg == adcc_pkg::ST_CONV)
                    & (cnt_reg == adcc_pkg::BITS_LAST);
  assign sar_decide = ce & ~abort & (state_reg == adcc_pkg::ST_CONV)
                      & (cnt_reg[1:0] == adcc_pkg::DECIDE_PH);

  // ==========================================================
  // Conversion sequencer and registers
  // ==========================================================
  // result kept while done
  // Abort leaves the done flag and result alone
  always_comb begin
    state_next                 = state_reg;
    cnt_next                   = cnt_reg;
    start_busy_bit_next        = start_busy_bit_reg;
    conversion_done_flag_next  = done_after_wr;
    external_start_enable_next = external_start_enable_reg;
    channel_select_next        = channel_select_reg;
    result_high_byte_next      = result_high_byte_reg;
    result_low_next            = result_low_reg;
    sar_load                   = 1'h0;
    if (wr_ctrl) begin
      external_start_enable_next = w_data_reg[adcc_pkg::B_EXT];
      if (!conversion_done_flag_reg && !start_busy_bit_reg) begin
        channel_select_next = w_data_reg[adcc_pkg::CH_W-1:0];
      end
    end
    unique case (state_reg)
      adcc_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_next          = adcc_pkg::ST_INIT1;
          cnt_next            = 6'h00;
          start_busy_bit_next = start_busy_bit_reg | sw_start;
        end
      end
      adcc_pkg::ST_INIT1: begin
        state_next          = adcc_pkg::ST_INIT2;
        start_busy_bit_next = 1'h1;
      end
      adcc_pkg::ST_INIT2: begin
        state_next = adcc_pkg::ST_SAMPLE;
        cnt_next   = 6'h00;
      end
      adcc_pkg::ST_SAMPLE: begin
        cnt_next = 6'(cnt_reg + 6'h01);
        if (cnt_reg == adcc_pkg::SMP_LAST) begin
          state_next = adcc_pkg::ST_CONV;
          cnt_next   = 6'h00;
          sar_load   = 1'h1;
        end
      end
      adcc_pkg::ST_CONV: begin
        cnt_next = 6'(cnt_reg + 6'h01);
        if (conv_end) begin
          // result in, busy out, done set
          state_next                = adcc_pkg::ST_IDLE;
          start_busy_bit_next       = 1'h0;
          conversion_done_flag_next = 1'h1;
          result_high_byte_next     = dac_code[9:2];
          result_low_next           = dac_code[1:0];
        end
      end
      default: begin
        state_next = adcc_pkg::ST_IDLE;
      end
    endcase
    if (abort) begin
      state_next          = adcc_pkg::ST_IDLE;
      start_busy_bit_next = 1'h0;
      sar_load            = 1'h0;
    end
  end

  // Whole state frozen while the clock enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                 <= adcc_pkg::ST_IDLE;
      cnt_reg                   <= 6'h00;
      start_busy_bit_reg        <= adcc_pkg::CTRL_RST[adcc_pkg::B_BUSY];
      conversion_done_flag_reg  <= adcc_pkg::CTRL_RST[adcc_pkg::B_DONE];
      external_start_enable_reg <= adcc_pkg::CTRL_RST[adcc_pkg::B_EXT];
      channel_select_reg        <= adcc_pkg::CTRL_RST[adcc_pkg::CH_W-1:0];
      result_high_byte_reg      <= 8'h00;
      result_low_reg            <= adcc_pkg::CTRL_RST[7:6];
      pin_prev_reg              <= 1'h0;
    end else if (ce) begin
      state_reg                 <= state_next;
      cnt_reg                   <= cnt_next;
      start_busy_bit_reg        <= start_busy_bit_next;
      conversion_done_flag_reg  <= conversion_done_flag_next;
      external_start_enable_reg <= external_start_enable_next;
      channel_select_reg        <= channel_select_next;
      result_high_byte_reg      <= result_high_byte_next;
      result_low_reg            <= result_low_next;
      pin_prev_reg              <= external_start_pin;
    end
  end

  // ==========================================================
  // Analog side
  // ==========================================================
  // binary code straight to the mux
  assign analog_channel_sel   = channel_select_reg;
  assign sample_en            = (state_reg == adcc_pkg::ST_SAMPLE);
  assign conversion_done_flag = conversion_done_flag_reg;

  adcc_sar u_sar (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .load      (sar_load),
    .decide    (sar_decide),
    .cmp_above (cmp_above),
    .dac_code  (dac_code)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  // Age is the index of the current conversion cycle, 0 in the first
  logic [5:0] age_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= 6'h00;
    end else if (ce) begin
      age_reg <= (state_reg == adcc_pkg::ST_IDLE) ? 6'h00
                 : 6'(age_reg + 6'h01);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_len;
    ce && conv_end |-> age_reg == adcc_pkg::AGE_END;
  endproperty
  a_len: assert property (p_len) else $error("length wrong");

  property p_res;
    ce && conv_end |=> result_high_byte_reg == $past(dac_code[9:2])
                       && result_low_reg == $past(dac_code[1:0]);
  endproperty
  a_res: assert property (p_res) else $error("result wrong");

  property p_hold;
    $past(conversion_done_flag_reg) && conversion_done_flag_reg
      |-> $stable({result_high_byte_reg, result_low_reg});
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");

  property p_norestart;
    ce && state_reg != adcc_pkg::ST_IDLE |=> state_reg != adcc_pkg::ST_INIT1;
  endproperty
  a_norestart: assert property (p_norestart) else $error("restart");

  property p_blocked;
    conversion_done_flag_reg && !wr_ctrl
      |=> state_reg != adcc_pkg::ST_INIT1;
  endproperty
  a_blocked: assert property (p_blocked) else $error("start taken");

  property p_abort;
    ce && abort |=> state_reg == adcc_pkg::ST_IDLE && !start_busy_bit_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");

  property p_idlekeep;
    ce && idle_mode && conversion_done_flag_reg && !wr_ctrl
      |=> conversion_done_flag_reg;
  endproperty
  a_idlekeep: assert property (p_idlekeep) else $error("done lost");

  property p_ext;
    ce && ext_rise && !abort && !wr_ctrl && !start_busy_bit_reg
      && !conversion_done_flag_reg && state_reg == adcc_pkg::ST_IDLE
      |=> state_reg == adcc_pkg::ST_INIT1 ##1 start_busy_bit_reg [*1];
  endproperty
  a_ext: assert property (p_ext) else $error("pin start lost");

  property p_init;
    ce && !abort && state_reg == adcc_pkg::ST_INIT1
      |=> start_busy_bit_reg && state_reg == adcc_pkg::ST_INIT2;
  endproperty
  a_init: assert property (p_init) else $error("init wrong");

  property p_done;
    ce && conv_end |=> conversion_done_flag_reg && !start_busy_bit_reg;
  endproperty
  a_done: assert property (p_done) else $error("done wrong");

  property p_chan;
    conversion_done_flag_reg || start_busy_bit_reg
      |=> $stable(channel_select_reg);
  endproperty
  a_chan: assert property (p_chan) else $error("channel moved");

endmodule : adcc_top

/* adcc_analog_model.sv */
/*
  Far-side model: eight analog levels, sample hold, comparator.
  Assumes mux code and sample strobe come from converter control.
*/
`timescale 1ns/1ps
module adcc_analog_model (
  input  wire logic        clk,
  input  wire logic [79:0] levels,
  input  wire logic [2:0]  chan,
  input  wire logic        sample_en,
  input  wire logic [9:0]  dac_code,
  output logic             cmp_above
);
  logic [9:0] held;

  // ==========
  // Sample and compare
  // ==========
  // hold selected input
  always_ff @(posedge clk) begin
    if (sample_en) begin
      held <= levels[chan*10 +: 10];
    end
  end

  // Held level rather than live one: slew during resolve is ignored
  assign cmp_above = (held >= dac_code);
endmodule : adcc_analog_model

/* testbench.sv */
/*
  Self-checking bench for converter control, with bench model.
  Assumes adcc_top and the analog model; one 25 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module testbench;
  logic        clk, rst_n, ce, idle_mode, power_down, pin;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  sel, ch;
  logic [9:0]  dac, lvl [8];
  logic [79:0] levels;
  logic        smp, done, cmp;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          n, k, smp_cnt;

  adcc_top uut (.clk(clk), .rst_n(rst_n), .ce(ce), .idle_mode(idle_mode), .power_down(power_down),
    .external_start_pin(pin), .cmp_above(cmp), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .analog_channel_sel(sel), .sample_en(smp),
    .dac_code(dac), .conversion_done_flag(done));
  adcc_analog_model model (.clk(clk), .levels(levels), .chan(sel), .sample_en(smp),
    .dac_code(dac), .cmp_above(cmp));

  // ==========
  // Clock, levels, sample counter
  // ==========
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always_comb for (int i = 0; i < 8; i++) levels[i*10 +: 10] = lvl[i];
  always @(posedge clk) if (smp === 1'b1) smp_cnt <= smp_cnt + 1;

  // ==========
  // Tasks
  // ==========
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    logic pa, pw;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awready === 1'b1) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (pw && wready === 1'b1) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    rsp = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic wait_done(input int lim);
    n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_done

  // Bench model: result of channel c with given external enable
  task automatic check_conv(input logic [2:0] c, input logic x);
    axr(adcc_pkg::CTRL_ADDR);
    `CHK(rd, {lvl[c][1:0], x, 2'h2, c});
    axr(adcc_pkg::RES_ADDR);
    `CHK(rd, lvl[c][9:2]);
  endtask : check_conv

  // ==========
  // Watchdog
  // ==========
  initial begin
    #800000;
    num_errors++;
    tally_and_finish();
  end

  // ==========
  // Scenarios
  // ==========
  initial begin
    {rst_n, idle_mode, power_down, pin, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, smp_cnt} = '0;
    ce = 1'b1;
    void'($urandom(600));
    for (k = 0; k < 8; k++) lvl[k] = 10'($urandom);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    axr(adcc_pkg::CTRL_ADDR);
    `CHK(rd, adcc_pkg::CTRL_RST);
    `CHK(rsp, adcc_pkg::RESP_OKAY);
    axr(12'h100);
    `CHK(rsp, adcc_pkg::RESP_ERR);
    `CHK(rd, 32'h0);
    axw(adcc_pkg::RES_ADDR, 8'hFF);
    `CHK(rsp, adcc_pkg::RESP_OKAY);
    // Every channel; start and channel change while busy are lost
    for (k = 0; k < 8; k++) begin
      ch = 3'(k);
      axw(adcc_pkg::CTRL_ADDR, {5'h00, ch});
      `CHK(sel, ch);
      axw(adcc_pkg::CTRL_ADDR, {5'h19, ch});
      axr(adcc_pkg::CTRL_ADDR);
      `CHK(rd[4:3], 2'h1);
      axw(adcc_pkg::CTRL_ADDR, {5'h01, ~ch});
      `CHK(sel, ch);
      wait_done(100);
      check_conv(ch, 1'b0);
      axw(adcc_pkg::CTRL_ADDR, {5'h00, ch});
    end
    // Done high: starts lost, result kept through idle
    axw(adcc_pkg::CTRL_ADDR, 8'h0D);
    wait_done(100);
    lvl[5] = ~lvl[5];
    axw(adcc_pkg::CTRL_ADDR, 8'h3A);
    pin <= 1'b1;
    repeat (3) @(posedge clk);
    pin <= 1'b0;
    idle_mode <= 1'b1;
    repeat (30) @(posedge clk);
    idle_mode <= 1'b0;
    repeat (60) @(posedge clk);
    lvl[5] = ~lvl[5];
    check_conv(3'h5, 1'b1);
    // Clear done and start together: same channel
    lvl[5] = 10'($urandom);
    axw(adcc_pkg::CTRL_ADDR, 8'h2A);
    wait_done(100);
    `CHK(sel, 3'h5);
    check_conv(3'h5, 1'b1);
    // Pin start: taken one edge after rise, done 50 later, seen next
    axw(adcc_pkg::CTRL_ADDR, 8'h25);
    smp_cnt = 0;
    @(posedge clk);
    pin <= 1'b1;
    wait_done(100);
    `CHK(n, 52);
    `CHK(smp_cnt, 8);
    check_conv(3'h5, 1'b1);
    pin <= 1'b0;
    axw(adcc_pkg::CTRL_ADDR, 8'h05);
    pin <= 1'b1;
    wait_done(70);
    `CHK(done, 1'b0);
    pin <= 1'b0;
    // Abort by idle, then by power-down
    for (k = 0; k < 2; k++) begin
      axw(adcc_pkg::CTRL_ADDR, 8'h0D);
      repeat (20) @(posedge clk);
      if (k == 0) idle_mode <= 1'b1;
      else power_down <= 1'b1;
      wait_done(70);
      `CHK(done, 1'b0);
      idle_mode <= 1'b0;
      power_down <= 1'b0;
      axr(adcc_pkg::CTRL_ADDR);
      `CHK(rd[4:3], 2'h0);
    end
    axw(adcc_pkg::CTRL_ADDR, 8'h0D);
    wait_done(100);
    check_conv(3'h5, 1'b0);
    tally_and_finish();
  end
endmodule : testbench
